// >>> design/dicr_defs.svh
// Behaviour
// - alarm enable set drives alarm pin; cleared leaves it undriven
// - polarity bit zero gives active-low alarm, one gives active-high
// - divider sync enable lets the sync source realign the divider
// - bit 1 enables inverse sinc on pair one, bit 0 on pair two
// - pattern test enable runs checker and forces outputs inactive
// - auto-clear enable clears alarm flags after 64 good samples
// - word parity checked against parity input, odd when bit 11 set
// - frame parity enable checks frame input and flags its alarm
// - invert bit 7 complements the whole data word; invert bits 4 to 6 do nothing
// - fifo distance alarms reported only while enabled; enables reset one
// - width bit selects word-wide transfers, cleared selects byte-wide
// - clock loss or collision shuts outputs when enabled and unmasked
// - serial-mode bit selects four-wire port, cleared three-wire
// - mixer enable, mixer gain and oscillator enable bits
// - reverse bit flips bus order; format bit selects two's complement
// - transmit enable is software bit or external pin
// - pattern test sets failing line bits; cleared by a write
// - write pointer of all zeros flags alarm and stalls until sync
// - fifo field encodes normal, two apart, one apart, collision
// - shutoff alarm set by clock loss or collision; outputs 0x8000
// - separate rising and falling parity flags plus pattern flag
// - temperature as signed byte in the upper byte, read only
// - 16-bit mask gates each alarm onto the pin, all masked at reset
`ifndef DICR_DEFS_SVH
`define DICR_DEFS_SVH
`define DICR_A_MAIN 7'h00
`define DICR_A_CHK 7'h01
`define DICR_A_FMT 7'h02
`define DICR_A_TX 7'h03
`define DICR_A_PAT 7'h04
`define DICR_A_ALM 7'h05
`define DICR_A_TEMP 7'h06
`define DICR_A_MASK 7'h07
`define DICR_R_MAIN 16'h049C
`define DICR_R_CHK 16'h050E
`define DICR_R_FMT 16'h7000
`define DICR_R_TX 16'hF000
`define DICR_R_MASK 16'hFFFF
`define DICR_R_ZERO 16'h0000
`define DICR_MID 16'h8000
`define DICR_GOOD_RUN 7'h40
`define DICR_PTR_INIT 8'h01
`define DICR_PTR_DEAD 8'h00
// buffer occupancy at which the distance alarms are raised
`define DICR_LVL_TWO 6'h1E
`define DICR_LVL_ONE 6'h1F
`define DICR_LVL_COL 6'h20
// main control bits
`define B_INVCD 0
`define B_INVAB 1
`define B_DSYNC 2
`define B_POL 3
`define B_AOE 4
// check control bits
`define B_ALCOL 1
`define B_AL1 2
`define B_AL2 3
`define B_INV_LO 4
`define B_FRPAR 9
`define B_WPAR 10
`define B_ODD 11
`define B_AUTO 12
`define B_PTEST 15
// format control bits
`define B_TWOS 1
`define B_REV 3
`define B_NCO 4
`define B_MGAIN 5
`define B_MIX 6
`define B_SIF4 7
`define B_COLG 12
`define B_DATG 13
`define B_DACG 14
`define B_WIDE 15
// alarm status bits
`define B_FPAR 2
`define B_LPAR 3
`define B_RPAR 4
`define B_PLL 5
`define B_IOT 7
`define B_OUTG 8
`define B_DATCLK 9
`define B_DACCLK 10
`define B_F2 11
`define B_F1 12
`define B_FCOL 13
`define B_ZCHK 15
`define B_TXSW 0
`define ALM_USED 16'hBFBC
`endif

// >>> design/dicr_fifo.sv
`timescale 1ns/1ps
module dicr_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count; the pointers
  // wrap on their own, so the depth must be a power of two
  assign in_ready = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid = cnt_ff != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ff];
  assign level = cnt_ff;

  always_ff @(posedge clock)
  begin
    if (push)
      mem_ff[wr_ff] <= in_data;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= wr_ff + 1'b1;
      if (pop)
        rd_ff <= rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> design/dicr_pkg.sv
package dicr_pkg;
  typedef enum logic [1:0] {
    DICR_IDLE = 2'b00,
    DICR_RUN = 2'b01,
    DICR_STUCK = 2'b11
  } dicr_ptr_e;
endpackage

// >>> design/dicr_regs.sv
`timescale 1ns/1ps
`include "dicr_defs.svh"
module dicr_regs
  import dicr_pkg::*;
#(
  parameter logic [7:0] VERSION_ID = 8'h5A // arbitrary value
) (
  input wire logic clock,
  input wire logic sys_rst,
  // register port: write strobe with address and data, read combinational
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic four_wire_sel_unused,
  // input data source
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [15:0] in_data,
  input wire logic parity_input,
  input wire logic frame_input,
  input wire logic rise_edge,
  // monitors and sensors
  input wire logic dac_clk_lost,
  input wire logic data_clk_lost,
  input wire logic pll_unlock,
  input wire logic sync_pulse,
  input wire logic [7:0] temp_code,
  input wire logic [15:0] test_pattern,
  input wire logic tx_enable_pin,
  // output sample stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data,
  // alarm pin
  output logic alarm_o,
  output logic alarm_oe,
  // configuration decodes
  output logic pair1_sinc_comp_enable,
  output logic pair2_sinc_comp_enable,
  output logic div_resync,
  output logic four_wire_control_port,
  output logic word_wide_input,
  output logic mixer_enable,
  output logic mixer_gain_6db,
  output logic nco_enable,
  output logic tx_active
);
  logic [15:0] main_ff;
  logic [15:0] chk_ff;
  logic [15:0] fmt_ff;
  logic [15:0] tx_ff;
  logic [15:0] pat_ff;
  logic [15:0] alm_ff;
  logic [15:0] mask_ff;
  logic [7:0] temp_ff;
  logic [7:0] wptr_ff;
  logic [6:0] good_ff;
  logic [15:0] out_ff;
  logic outv_ff;
  dicr_ptr_e ptr_ff;
  logic [16:0] f_out;
  logic f_valid;
  logic [5:0] f_level;
  logic [15:0] nxt_alm_set;
  logic [15:0] shaped;
  logic par_bad;
  logic fr_bad;
  logic pat_bad;
  logic acc;
  logic shutoff;
  logic [2:0] fifo_code;
  logic sample_ok;
  logic auto_clr;
  logic [15:0] pat_set;

  // reversal helper used on the data path only; the pattern test compares unreversed input
  function automatic logic [15:0] rev16(input logic [15:0] d);
    for (int i = 0; i < 16; i++)
      rev16[i] = d[15-i];
  endfunction

  assign acc = in_valid && in_ready;

  // 32-deep buffer between input capture and the output stage
  dicr_fifo #(.WIDTH(17), .DEPTH(32)) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data({rise_edge, in_data}),
    .out_valid(f_valid),
    .out_ready(out_ready || !outv_ff),
    .out_data(f_out),
    .level(f_level)
  );

  // configuration register writes
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      main_ff <= `DICR_R_MAIN;
      chk_ff <= `DICR_R_CHK;
      fmt_ff <= `DICR_R_FMT;
      tx_ff <= `DICR_R_TX;
      mask_ff <= `DICR_R_MASK;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `DICR_A_MAIN: main_ff <= reg_wdata;
        `DICR_A_CHK: chk_ff <= reg_wdata;
        `DICR_A_FMT: fmt_ff <= reg_wdata;
        `DICR_A_TX: tx_ff <= reg_wdata;
        `DICR_A_MASK: mask_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // decoded controls
  assign pair1_sinc_comp_enable = main_ff[`B_INVAB];
  assign pair2_sinc_comp_enable = main_ff[`B_INVCD];
  assign div_resync = main_ff[`B_DSYNC] && sync_pulse;
  assign four_wire_control_port = fmt_ff[`B_SIF4];
  assign word_wide_input = fmt_ff[`B_WIDE];
  assign mixer_enable = fmt_ff[`B_MIX];
  assign mixer_gain_6db = fmt_ff[`B_MGAIN];
  assign nco_enable = fmt_ff[`B_NCO];

  // parity of the arriving word, byte mode checks only the low byte
  always_comb
  begin
    logic p;
    p = word_wide_input ? ^in_data : ^in_data[7:0];
    par_bad = chk_ff[`B_WPAR] && ((p ^ parity_input) != chk_ff[`B_ODD]);
    fr_bad = chk_ff[`B_FRPAR] && ((p ^ frame_input) != chk_ff[`B_ODD]);
  end

  assign pat_bad = chk_ff[`B_PTEST] && (in_data != test_pattern);

  // fifo distance from occupancy: free slots left decide nearness
  always_comb
  begin
    fifo_code = 3'b000;
    if (f_level == `DICR_LVL_COL)
      fifo_code = 3'b100;
    else if (f_level == `DICR_LVL_ONE)
      fifo_code = 3'b010;
    else if (f_level == `DICR_LVL_TWO)
      fifo_code = 3'b001;
  end

  // hardware set terms for the sticky flags
  always_comb
  begin
    nxt_alm_set = '0;
    nxt_alm_set[`B_RPAR] = acc && par_bad && rise_edge;
    nxt_alm_set[`B_LPAR] = acc && par_bad && !rise_edge;
    nxt_alm_set[`B_FPAR] = acc && fr_bad;
    nxt_alm_set[`B_IOT] = acc && pat_bad;
    nxt_alm_set[`B_PLL] = pll_unlock;
    nxt_alm_set[`B_DACCLK] = dac_clk_lost;
    nxt_alm_set[`B_DATCLK] = data_clk_lost;
    nxt_alm_set[`B_F2] = fifo_code[0] && chk_ff[`B_AL2];
    nxt_alm_set[`B_F1] = fifo_code[1] && chk_ff[`B_AL1];
    nxt_alm_set[`B_FCOL] = fifo_code[2] && chk_ff[`B_ALCOL];
    nxt_alm_set[`B_ZCHK] = ptr_ff == DICR_STUCK;
    // raised by the new events only, so one write can clear cause and
    // shutoff together; a sticky cause would otherwise re-raise it
    nxt_alm_set[`B_OUTG] = dac_clk_lost || data_clk_lost
      || nxt_alm_set[`B_FCOL];
  end

  // auto-clear is a single pulse, so flags raised later stay sticky
  assign sample_ok = !(par_bad || fr_bad || pat_bad);
  assign auto_clr = chk_ff[`B_AUTO] && acc && sample_ok
    && good_ff == `DICR_GOOD_RUN - 1'b1;

  // sticky status; a set in the same cycle as a clear wins
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      alm_ff <= `DICR_R_ZERO;
    else if (auto_clr)
      alm_ff <= nxt_alm_set & `ALM_USED;
    else if (reg_wr && reg_addr == `DICR_A_ALM)
      alm_ff <= (alm_ff & ~reg_wdata | nxt_alm_set) & `ALM_USED;
    else
      alm_ff <= (alm_ff | nxt_alm_set) & `ALM_USED;
  end

  // run of consecutive good samples for auto-clear
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      good_ff <= '0;
    else if (acc)
    begin
      if (!sample_ok || good_ff == `DICR_GOOD_RUN - 1'b1)
        good_ff <= '0;
      else
        good_ff <= good_ff + 1'b1;
    end
  end

  // one-hot shift write pointer; zero state sticks until sync
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wptr_ff <= `DICR_PTR_INIT;
      ptr_ff <= DICR_IDLE;
    end
    else if (sync_pulse)
    begin
      wptr_ff <= `DICR_PTR_INIT;
      ptr_ff <= DICR_RUN;
    end
    else
    begin
      unique case (ptr_ff)
        DICR_IDLE: ptr_ff <= DICR_RUN;
        DICR_RUN:
        begin
          if (wptr_ff == `DICR_PTR_DEAD)
            ptr_ff <= DICR_STUCK;
          else if (acc)
            wptr_ff <= {wptr_ff[6:0], wptr_ff[7]};
        end
        DICR_STUCK: ;
        default: ptr_ff <= DICR_IDLE;
      endcase
    end
  end

  // pattern failures per data line; a write clears, a new failure wins
  assign pat_set = (acc && chk_ff[`B_PTEST]) ? in_data ^ test_pattern
    : `DICR_R_ZERO;
  always_ff @(posedge clock)
  begin
    if (reg_wr && reg_addr == `DICR_A_PAT)
      pat_ff <= pat_set;
    else
      pat_ff <= pat_ff | pat_set;
  end

  always_ff @(posedge clock)
  begin
    temp_ff <= temp_code;
  end

  // transmit gating and shutoff
  assign tx_active = (tx_ff[`B_TXSW] || tx_enable_pin)
    && !chk_ff[`B_PTEST];
  assign shutoff = alm_ff[`B_OUTG] && !mask_ff[`B_OUTG] && (
    (fmt_ff[`B_DACG] && alm_ff[`B_DACCLK] && !mask_ff[`B_DACCLK]) ||
    (fmt_ff[`B_DATG] && alm_ff[`B_DATCLK] && !mask_ff[`B_DATCLK]) ||
    (fmt_ff[`B_COLG] && alm_ff[`B_FCOL] && !mask_ff[`B_FCOL]));

  // data shaping: reverse, invert whole word on check bit 7, then offset format
  always_comb
  begin
    logic [15:0] d;
    d = fmt_ff[`B_REV] ? rev16(f_out[15:0]) : f_out[15:0];
    if (chk_ff[`B_INV_LO + 3 - 0] || chk_ff[`B_INV_LO + 3 - 1]
        || chk_ff[`B_INV_LO + 3 - 2] || chk_ff[`B_INV_LO])
      d = chk_ff[`B_INV_LO + 3 - 0] ? ~d : d;
    shaped = fmt_ff[`B_TWOS] ? d ^ `DICR_MID : d;
  end

  // output stage: inactive under shutoff or no transmit enable
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_ff <= `DICR_MID;
      outv_ff <= 1'b0;
    end
    else if (out_ready || !outv_ff)
    begin
      outv_ff <= f_valid;
      if (shutoff || !tx_active)
        out_ff <= `DICR_MID;
      else
        out_ff <= shaped;
    end
  end
  assign out_valid = outv_ff;
  assign out_data = out_ff;

  // alarm pin: masked or, polarity, tristate control
  assign alarm_oe = main_ff[`B_AOE];
  assign alarm_o = (|(alm_ff & ~mask_ff)) ~^ main_ff[`B_POL];

  // read mux
  always_comb
  begin
    unique case (reg_addr)
      `DICR_A_MAIN: reg_rdata = main_ff;
      `DICR_A_CHK: reg_rdata = chk_ff;
      `DICR_A_FMT: reg_rdata = fmt_ff;
      `DICR_A_TX: reg_rdata = tx_ff;
      `DICR_A_PAT: reg_rdata = pat_ff;
      `DICR_A_ALM: reg_rdata = alm_ff;
      `DICR_A_TEMP: reg_rdata = {temp_ff, 8'h00};
      `DICR_A_MASK: reg_rdata = mask_ff;
      default: reg_rdata = {8'h00, VERSION_ID};
    endcase
  end

  property p_oe;
    @(posedge clock) disable iff (sys_rst) alarm_oe == main_ff[`B_AOE];
  endproperty
  a_oe: assert property (p_oe) else $error("alarm enable");
  property p_shut;
    @(posedge clock) disable iff (sys_rst)
      (shutoff && (out_ready || !outv_ff)) |=> out_data == `DICR_MID;
  endproperty
  a_shut: assert property (p_shut) else $error("shutoff");
  property p_ptest;
    @(posedge clock) disable iff (sys_rst) chk_ff[`B_PTEST] |-> !tx_active;
  endproperty
  a_ptest: assert property (p_ptest) else $error("pattern tx");
  property p_tx;
    @(posedge clock) disable iff (sys_rst)
      (tx_enable_pin && !chk_ff[`B_PTEST]) |-> tx_active;
  endproperty
  a_tx: assert property (p_tx) else $error("tx or");
  property p_sticky;
    @(posedge clock) disable iff (sys_rst)
      (alm_ff[`B_RPAR] && !reg_wr && !chk_ff[`B_AUTO]) |=> alm_ff[`B_RPAR];
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky");
  property p_zchk;
    @(posedge clock) disable iff (sys_rst)
      (ptr_ff == DICR_STUCK && !sync_pulse) |=> alm_ff[`B_ZCHK];
  endproperty
  a_zchk: assert property (p_zchk) else $error("zero chk");
  property p_outg;
    @(posedge clock) disable iff (sys_rst)
      $rose(alm_ff[`B_DACCLK]) |-> alm_ff[`B_OUTG];
  endproperty
  a_outg: assert property (p_outg) else $error("output gone");
  property p_mask;
    @(posedge clock) disable iff (sys_rst)
      (mask_ff == `DICR_R_MASK) |-> alarm_o == !main_ff[`B_POL];
  endproperty
  a_mask: assert property (p_mask) else $error("mask");

  // the last sample of a good run in auto-clear mode
  sequence s_run_end;
    acc && sample_ok && good_ff == `DICR_GOOD_RUN - 1'b1;
  endsequence
  property p_auto;
    @(posedge clock) disable iff (sys_rst)
      chk_ff[`B_AUTO] ##0 s_run_end
      |=> !alm_ff[`B_RPAR] && !alm_ff[`B_LPAR] && !alm_ff[`B_FPAR];
  endproperty
  a_auto: assert property (p_auto) else $error("auto clear");
  property p_col;
    @(posedge clock) disable iff (sys_rst)
      (f_level == `DICR_LVL_COL && chk_ff[`B_ALCOL])
      |=> alm_ff[`B_FCOL] && alm_ff[`B_OUTG];
  endproperty
  a_col: assert property (p_col) else $error("collision");
  property p_far;
    @(posedge clock) disable iff (sys_rst)
      (!chk_ff[`B_AL2] && !alm_ff[`B_F2] && !reg_wr) |=> !alm_ff[`B_F2];
  endproperty
  a_far: assert property (p_far) else $error("two apart");
  property p_pat;
    @(posedge clock) disable iff (sys_rst)
      (acc && chk_ff[`B_PTEST] && in_data[0] != test_pattern[0])
      |=> pat_ff[0];
  endproperty
  a_pat: assert property (p_pat) else $error("pattern line");
endmodule

// >>> tb/dicr_src.sv
`timescale 1ns/1ps
// data source model: holds each sample until the block takes it or eight cycles pass
module dicr_src (
  input wire logic clock,
  input wire logic in_ready,
  output logic in_valid,
  output logic [15:0] in_data,
  output logic parity_input,
  output logic frame_input,
  output logic rise_edge
);
  initial
  begin
    in_valid = 1'b0;
    in_data = 16'h0000;
    parity_input = 1'b0;
    frame_input = 1'b0;
    rise_edge = 1'b1;
  end
  // parity over the selected width; pb and fb corrupt it on purpose
  task automatic send(input logic [15:0] d, input logic wide,
    input logic odd, input logic pb, input logic fb, input logic r,
    output logic ok);
    logic p;
    logic acc;
    p = (wide ? ^d : ^d[7:0]) ^ odd;
    in_valid <= 1'b1;
    in_data <= d;
    parity_input <= p ^ pb;
    frame_input <= p ^ fb;
    rise_edge <= r;
    ok = 1'b0;
    repeat (8)
    begin
      @(negedge clock);
      acc = in_ready;
      @(posedge clock);
      if (acc === 1'b1)
      begin
        ok = 1'b1;
        break;
      end
    end
  endtask
  // released lines show the inverse so stale data never passes
  task automatic idle();
    in_valid <= 1'b0;
    in_data <= ~in_data;
    parity_input <= ~parity_input;
    frame_input <= ~frame_input;
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] VID = 8'h3C; // arbitrary value
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] test_pattern = 16'h0000;
  logic [7:0] temp_code = 8'h00;
  logic [2:0] ev = 3'h0;
  logic sync_pulse = 1'b0;
  logic tx_enable_pin = 1'b0;
  logic out_ready = 1'b0;
  logic [15:0] reg_rdata, in_data, out_data;
  logic in_valid, in_ready, parity_input, frame_input, rise_edge;
  logic out_valid, alarm_o, alarm_oe, p1, p2, dsync, fw, ww;
  logic mx, mg, nco, txa, ok;
  int failures = 0;
  int total_checks = 0;

  always #12.5 clock = ~clock;

  dicr_regs #(.VERSION_ID(VID)) dut_u (.clock(clock), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .four_wire_sel_unused(1'b0),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .parity_input(parity_input), .frame_input(frame_input),
    .rise_edge(rise_edge), .dac_clk_lost(ev[0]),
    .data_clk_lost(ev[1]), .pll_unlock(ev[2]), .sync_pulse(sync_pulse),
    .temp_code(temp_code), .test_pattern(test_pattern),
    .tx_enable_pin(tx_enable_pin), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .alarm_o(alarm_o),
    .alarm_oe(alarm_oe), .pair1_sinc_comp_enable(p1),
    .pair2_sinc_comp_enable(p2), .div_resync(dsync),
    .four_wire_control_port(fw), .word_wide_input(ww),
    .mixer_enable(mx), .mixer_gain_6db(mg), .nco_enable(nco),
    .tx_active(txa));

  dicr_src src_u (.clock(clock), .in_ready(in_ready),
    .in_valid(in_valid), .in_data(in_data),
    .parity_input(parity_input), .frame_input(frame_input),
    .rise_edge(rise_edge));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one write cycle, then a gap so the strobe never toggles twice
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  // read is combinational, so sample mid-cycle
  task automatic rc(input logic [6:0] a, input logic [15:0] exp,
    input logic [15:0] msk = 16'hFFFF);
    reg_addr <= a;
    @(negedge clock);
    chk(reg_rdata & msk, exp);
    @(posedge clock);
  endtask
  task automatic t_reset();
    rc(7'h00, 16'h049C);
    rc(7'h01, 16'h050E);
    rc(7'h02, 16'h7000);
    rc(7'h03, 16'hF000);
    rc(7'h07, 16'hFFFF);
    rc(7'h05, 16'h0000);
    chk({14'h0, alarm_oe, alarm_o}, 16'h0002);
  endtask
  task automatic t_cfg();
    wr(7'h00, 16'h0494);
    chk({14'h0, alarm_oe, alarm_o}, 16'h0003);
    wr(7'h00, 16'h048C);
    chk(16'(alarm_oe), 16'h0000);
    sync_pulse <= 1'b1;
    wr(7'h00, 16'h049F);
    chk({13'h0, p1, p2, dsync}, 16'h0007);
    wr(7'h00, 16'h0498);
    chk({13'h0, p1, p2, dsync}, 16'h0000);
    sync_pulse <= 1'b0;
    wr(7'h00, 16'h049C);
    wr(7'h02, 16'hF0F0);
    chk({11'h0, ww, fw, mx, mg, nco}, 16'h001F);
    wr(7'h02, 16'h7000);
    chk({11'h0, ww, fw, mx, mg, nco}, 16'h0000);
  endtask
  task automatic t_tx();
    for (int i = 0; i < 4; i++)
    begin
      tx_enable_pin <= i[1];
      wr(7'h03, {12'hF00, 3'h0, i[0]});
      chk(16'(txa), 16'(i != 0));
    end
    wr(7'h01, 16'h850E);
    chk(16'(txa), 16'h0000);
    wr(7'h01, 16'h050E);
    tx_enable_pin <= 1'b0;
  endtask
  task automatic t_alarm();
    logic [15:0] e [3] = '{16'h0500, 16'h0300, 16'h0020};
    for (int i = 0; i < 3; i++)
    begin
      ev[i] <= 1'b1;
      @(posedge clock);
      ev[i] <= 1'b0;
      repeat (2) @(posedge clock);
      rc(7'h05, e[i]);
      wr(7'h05, 16'hFFFF);
      rc(7'h05, 16'h0000);
    end
    ev[0] <= 1'b1;
    wr(7'h07, 16'hFBFF);
    chk(16'(alarm_o), 16'h0001);
    ev[0] <= 1'b0;
    wr(7'h05, 16'h0400);
    rc(7'h05, 16'h0100);
    wr(7'h07, 16'hFFFF);
    chk(16'(alarm_o), 16'h0000);
    wr(7'h05, 16'hFFFF);
  endtask
  task automatic pcase(input logic [15:0] cfg, input logic pb,
    input logic fb, input logic r, input logic [15:0] exp);
    wr(7'h01, cfg);
    src_u.send(16'h0037, 1'b0, cfg[11], pb, fb, r, ok);
    src_u.idle();
    repeat (4) @(posedge clock);
    rc(7'h05, exp);
    wr(7'h05, 16'hFFFF);
  endtask
  task automatic t_parity();
    out_ready <= 1'b1;
    pcase(16'h050E, 1'b1, 1'b0, 1'b1, 16'h0010);
    pcase(16'h050E, 1'b1, 1'b0, 1'b0, 16'h0008);
    pcase(16'h070E, 1'b0, 1'b1, 1'b1, 16'h0004);
    pcase(16'h0D0E, 1'b0, 1'b0, 1'b1, 16'h0000);
    pcase(16'h0D0E, 1'b1, 1'b0, 1'b1, 16'h0010);
    wr(7'h01, 16'h150E);
    src_u.send(16'h0011, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, ok);
    for (int i = 0; i < 64; i++)
    begin
      if (i == 63)
      begin
        src_u.idle();
        repeat (4) @(posedge clock);
        rc(7'h05, 16'h0010);
      end
      src_u.send(i[15:0], 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, ok);
    end
    src_u.idle();
    repeat (4) @(posedge clock);
    rc(7'h05, 16'h0000);
  endtask
  task automatic t_ptest();
    wr(7'h02, 16'hF000);
    wr(7'h01, 16'h850E);
    test_pattern <= 16'h00FF;
    wr(7'h04, 16'h0000);
    src_u.send(16'h00F0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, ok);
    src_u.idle();
    repeat (4) @(posedge clock);
    rc(7'h04, 16'h000F);
    rc(7'h05, 16'h0080, 16'h0080);
    wr(7'h04, 16'h1234);
    rc(7'h04, 16'h0000);
    wr(7'h05, 16'hFFFF);
  endtask
  // output held: 32 buffered words plus one in the output register
  task automatic fill(input logic [15:0] cfg, input logic [15:0] msk);
    int n;
    n = 0;
    wr(7'h01, cfg);
    wr(7'h07, msk);
    out_ready <= 1'b0;
    for (int i = 0; i < 34; i++)
    begin
      src_u.send(16'h1000 + 16'(i), 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, ok);
      if (ok === 1'b1)
        n++;
    end
    src_u.idle();
    chk(16'(n), 16'h0021);
  endtask
  // the first word was loaded before any shutoff could take effect
  task automatic drain(input logic shut);
    int n;
    n = 0;
    out_ready <= 1'b1;
    repeat (100)
    begin
      @(negedge clock);
      if (out_valid === 1'b1 && n < 33)
      begin
        if (shut && n > 0)
          chk(out_data, 16'h8000);
        else
          chk(out_data, 16'h1000 + 16'(n));
        n++;
      end
    end
    @(posedge clock);
    chk(16'(n), 16'h0021);
  endtask
  task automatic t_fifo();
    fill(16'h0500, 16'hFFFF);
    rc(7'h05, 16'h0000, 16'h3800);
    drain(1'b0);
    fill(16'h050E, 16'hDEFF);
    rc(7'h05, 16'h3900);
    chk(16'(alarm_o), 16'h0001);
    drain(1'b1);
    wr(7'h05, 16'hFFFF);
    rc(7'h05, 16'h0000);
    wr(7'h07, 16'hFFFF);
  endtask
  // reverse, bit 7 invert and format conversion on one word
  task automatic t_shape();
    wr(7'h02, 16'hF00A);
    wr(7'h01, 16'h058E);
    out_ready <= 1'b1;
    src_u.send(16'h1234, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, ok);
    src_u.idle();
    repeat (2) @(negedge clock);
    chk(16'(out_valid), 16'h0001);
    chk(out_data, 16'h53B7);
  endtask
  task automatic t_misc();
    temp_code <= 8'hE7;
    wr(7'h06, 16'h0000);
    rc(7'h06, 16'hE700, 16'hFFFC);
    rc(7'h10, {8'h00, VID}, 16'h00FF);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence after three cycles of reset
  initial
  begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_cfg();
    t_tx();
    t_alarm();
    t_parity();
    t_ptest();
    t_fifo();
    t_shape();
    t_misc();
    tally_and_finish();
  end
  // watchdog: whole run needs under a thousand cycles; limit is 40000
  initial
  begin
    #(25 * 40000);
    failures++;
    tally_and_finish();
  end
endmodule
